// File: shared/openload_pkg.sv
// Contract
// - On-state open load check runs automatically whenever a channel output is on.
// - On-state result sets quick fault bit, global open load flag and on-state status bit.
// - On-state flag stays latched until fault gone and channel status is read.
// - Detecting on-state open load never switches the output off.
// - Filter select bit: 0 gives 64 us deglitch, 1 gives 2 ms deglitch.
// - On-state filter counts only while output high, clears when output goes low.
// - LED-mode bit: 0 selects current-based check, 1 selects low-current LED check.
// - LED mode flags open when comparator high after 2 ms off, or at turn-on.
// - Under PWM, LED evaluation starts at end of on-period, lasts up to 2 ms.
// - LED test source switches off at no-fault result or after 2 ms.
// - Host trigger starts LED check on all LED-mode outputs; source off 100 us after reactivation.
// - Device clears the LED trigger bit itself once triggered detection finishes.
// - Off-state enable resets to 0; writing 1 starts test; writes ignored while active.
// - Selected off-state tests start together on chip select rising edge.
// - Off-state threshold reached before timeout: output off, enable cleared, no fault.
// - Threshold not reached by timeout: output off, enable cleared, off-state flag set.
// - Off-state test leaves overcurrent, current feedback and sense sync settings untouched.
// - Off-state fault shows in quick, global and status bits until channel status read.
// - Overtemperature, undervoltage or charge pump fault aborts the off-state test.
// - Off-state test timeout is 1.2 ms, within 0.9 to 1.5 ms.
package openload_pkg;
    localparam int CHANNELS = 5;
    localparam int CNT_W = 15;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // timebase and durations
    localparam int CLK_PERIOD_NS = 100;
    localparam int FILTER_SHORT_NS = 64000;
    localparam int FILTER_LONG_NS = 2000000;
    localparam int LED_WINDOW_NS = 2000000;
    localparam int LED_HOLD_NS = 100000;
    localparam int OFFTEST_NS = 1200000;
    localparam int FILTER_SHORT_CYCLES = (FILTER_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILTER_LONG_CYCLES = (FILTER_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LED_WINDOW_CYCLES = LED_WINDOW_NS / CLK_PERIOD_NS;
    localparam int LED_HOLD_CYCLES = (LED_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int OFFTEST_CYCLES = OFFTEST_NS / CLK_PERIOD_NS;

    // register offsets
    localparam logic [3:0] ADDR_FILTER = 4'h0;
    localparam logic [3:0] ADDR_LEDCTL = 4'h1;
    localparam logic [3:0] ADDR_OFFTEST = 4'h2;
    localparam logic [3:0] ADDR_QUICK = 4'h3;
    localparam logic [3:0] ADDR_CHAN0 = 4'h4;

    // field positions
    localparam int LED_TRIG_BIT = 5;
    localparam int QUICK_GLOBAL_BIT = 5;
    localparam int STAT_ONSTATE_BIT = 0;
    localparam int STAT_OFFSTATE_BIT = 1;

    // reset values
    localparam logic [4:0] FILTER_RESET = 5'h00;
    localparam logic [4:0] LEDMODE_RESET = 5'h00;
    localparam logic [4:0] OFFTEST_RESET = 5'h00;

    typedef enum logic [1:0] {TRIG_IDLE, TRIG_EVAL, TRIG_HOLD} trig_state_t;
endpackage

// File: design/openload_diag.sv
`timescale 1ns/100ps
module openload_diag #(
    parameter int unsigned FILTER_LONG_CYCLES = openload_pkg::FILTER_LONG_CYCLES,
    parameter int unsigned LED_WINDOW_CYCLES = openload_pkg::LED_WINDOW_CYCLES,
    parameter int unsigned OFFTEST_CYCLES = openload_pkg::OFFTEST_CYCLES
) (
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic [3:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [7:0] REG_RDATA,
    input wire logic CHIP_SELECT_N,
    input wire logic [4:0] OUT_HIGH,
    input wire logic [4:0] ON_CURRENT_LOW,
    input wire logic [4:0] LED_CMP_HIGH,
    input wire logic [4:0] OFF_CUR_REACHED,
    input wire logic OVERTEMP_SHUTDOWN,
    input wire logic SUPPLY_UNDERVOLTAGE,
    input wire logic CHARGE_PUMP_FAULT,
    output logic [4:0] OFFTEST_DRIVE,
    output logic [4:0] LED_SOURCE_EN,
    output logic [4:0] LED_TEST_OFF,
    output logic [4:0] QUICK_CHANNEL_FAULT,
    output logic GLOBAL_OPENLOAD_FLAG
);
    localparam int W = openload_pkg::CNT_W;
    localparam logic [W-1:0] SHORT_LIM = W'(openload_pkg::FILTER_SHORT_CYCLES);
    localparam logic [W-1:0] LONG_LIM = W'(FILTER_LONG_CYCLES);
    localparam logic [W-1:0] WIN_LIM = W'(LED_WINDOW_CYCLES);
    localparam logic [W-1:0] HOLD_LIM = W'(openload_pkg::LED_HOLD_CYCLES);
    localparam logic [W-1:0] OFF_LIM = W'(OFFTEST_CYCLES);

    // counters are W bits wide; longer or zero durations cannot be served
    if (FILTER_LONG_CYCLES < 1 || FILTER_LONG_CYCLES >= (1 << W) || LED_WINDOW_CYCLES < 1 ||
        LED_WINDOW_CYCLES >= (1 << W) || OFFTEST_CYCLES < 1 || OFFTEST_CYCLES >= (1 << W)) begin : g_bad_param
        $error("openload_diag: duration parameter out of counter range");
    end

    typedef struct packed {
        logic [23:0] sync1;
        logic [23:0] sync2;
        logic cs_prev;
        logic [4:0] out_prev;
        logic [4:0] filter_sel;
        logic [4:0] led_mode;
        logic [4:0] off_pending;
        logic [4:0] off_active;
        logic [W-1:0] off_cnt;
        logic [4:0][W-1:0] filt_cnt;
        logic [4:0] led_active;
        logic [4:0][W-1:0] led_cnt;
        logic trig;
        openload_pkg::trig_state_t trig_state;
        logic [W-1:0] trig_cnt;
        logic [4:0] led_src;
        logic [4:0] test_off;
        logic [4:0] on_flag;
        logic [4:0] off_flag;
        logic [4:0] quick;
        logic global;
        logic [7:0] rdata;
    } state_t;

    state_t s;
    state_t next_s;
    logic rst_meta;
    logic rst_n;

    // reset is released through two flip-flops, asserted at once
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // all block behaviour, computed from the present state
    always_comb begin
        logic [4:0] out_high;
        logic [4:0] cmp_high;
        logic [4:0] cur_low;
        logic [4:0] reached;
        logic cs_rise;
        logic fault;
        logic [4:0] on_raw;
        logic [4:0] on_set;
        logic [4:0] off_set;
        logic [4:0] rd_chan;
        logic led_start;
        logic [W-1:0] lim;
        logic [3:0] idx;
        out_high = s.sync2[4:0];
        cmp_high = s.sync2[9:5];
        cur_low = s.sync2[14:10];
        reached = s.sync2[19:15];
        fault = |s.sync2[23:21];
        cs_rise = s.sync2[20] & ~s.cs_prev;
        on_raw = 5'h00;
        on_set = 5'h00;
        off_set = 5'h00;
        rd_chan = 5'h00;
        led_start = 1'b0;
        lim = SHORT_LIM;
        idx = 4'h0;
        next_s = s;

        // pins come from outside the clock domain: two stages before use
        next_s.sync1 = {OVERTEMP_SHUTDOWN, SUPPLY_UNDERVOLTAGE, CHARGE_PUMP_FAULT, CHIP_SELECT_N,
                        OFF_CUR_REACHED, ON_CURRENT_LOW, LED_CMP_HIGH, OUT_HIGH};
        next_s.sync2 = s.sync1;
        next_s.cs_prev = s.sync2[20];
        next_s.out_prev = out_high;

        // register writes
        if (REG_WR) begin
            if (REG_ADDR == openload_pkg::ADDR_FILTER) begin
                next_s.filter_sel = REG_WDATA[4:0];
            end else if (REG_ADDR == openload_pkg::ADDR_LEDCTL) begin
                next_s.led_mode = REG_WDATA[4:0];
                if (REG_WDATA[openload_pkg::LED_TRIG_BIT] && s.trig_state == openload_pkg::TRIG_IDLE) begin
                    next_s.trig = 1'b1;
                end
            end else if (REG_ADDR == openload_pkg::ADDR_OFFTEST) begin
                if (s.off_active == 5'h00) begin
                    next_s.off_pending = REG_WDATA[4:0];
                end
            end
        end

        // off-state test: common start, common timeout, per-channel early finish
        // the test only asks the channel on; overcurrent, feedback and sense sync stay as programmed
        if (cs_rise && s.off_active == 5'h00 && next_s.off_pending != 5'h00) begin
            next_s.off_active = next_s.off_pending;
            next_s.off_pending = 5'h00;
            next_s.off_cnt = '0;
        end else if (s.off_active != 5'h00) begin
            if (fault) begin
                next_s.off_active = 5'h00;
            end else if (s.off_cnt == OFF_LIM - 1'b1) begin
                off_set = s.off_active & ~reached;
                next_s.off_active = 5'h00;
            end else begin
                next_s.off_active = s.off_active & ~reached;
                next_s.off_cnt = s.off_cnt + 1'b1;
            end
        end

        // per-channel on-state checks
        for (int i = 0; i < openload_pkg::CHANNELS; i++) begin
            // current-based check, armed while the output is on and the channel is not in LED mode
            lim = s.filter_sel[i] ? LONG_LIM : SHORT_LIM;
            on_raw[i] = out_high[i] & ~s.led_mode[i] & cur_low[i];
            if (!on_raw[i]) begin
                next_s.filt_cnt[i] = '0;
            end else if (s.filt_cnt[i] >= lim - 1'b1) begin
                on_set[i] = 1'b1; // flag only, output untouched
            end else begin
                next_s.filt_cnt[i] = s.filt_cnt[i] + 1'b1;
            end

            // LED check: armed at each falling edge of the output while no triggered check runs, or by trigger
            led_start = (s.trig_state == openload_pkg::TRIG_IDLE) &&
                        (s.trig || (s.out_prev[i] && !out_high[i]));
            if (!s.led_mode[i]) begin
                next_s.led_active[i] = 1'b0;
            end else if (s.led_active[i]) begin
                if (out_high[i] && s.trig_state != openload_pkg::TRIG_EVAL) begin
                    on_set[i] = 1'b1; // turned on before a good result
                    next_s.led_active[i] = 1'b0;
                end else if (!out_high[i] && !cmp_high[i]) begin
                    next_s.led_active[i] = 1'b0; // load present
                end else if (s.led_cnt[i] == WIN_LIM - 1'b1) begin
                    on_set[i] = cmp_high[i];
                    next_s.led_active[i] = 1'b0;
                end else begin
                    next_s.led_cnt[i] = s.led_cnt[i] + 1'b1;
                end
            end else if (led_start) begin
                next_s.led_active[i] = 1'b1;
                next_s.led_cnt[i] = '0;
            end

            // status read clears, the on-state flag only once on_raw is low; a new event in the same cycle wins
            rd_chan[i] = REG_RD && (REG_ADDR == openload_pkg::ADDR_CHAN0 + 4'(i));
            next_s.on_flag[i] = on_set[i] | (s.on_flag[i] & ~(rd_chan[i] & ~on_raw[i]));
            next_s.off_flag[i] = off_set[i] | (s.off_flag[i] & ~rd_chan[i]);
        end

        // triggered LED check for fully-on outputs
        case (s.trig_state)
            openload_pkg::TRIG_IDLE: begin
                if (s.trig) begin
                    next_s.trig_state = openload_pkg::TRIG_EVAL;
                end
            end
            openload_pkg::TRIG_EVAL: begin
                if ((next_s.led_active & s.led_mode) == 5'h00) begin
                    next_s.trig_state = openload_pkg::TRIG_HOLD;
                    next_s.trig_cnt = '0;
                end
            end
            openload_pkg::TRIG_HOLD: begin
                // source stays on a short while after the outputs come back
                if (s.trig_cnt == HOLD_LIM - 1'b1) begin
                    next_s.trig_state = openload_pkg::TRIG_IDLE;
                    next_s.trig = 1'b0;
                end else begin
                    next_s.trig_cnt = s.trig_cnt + 1'b1;
                end
            end
            default: begin
                next_s.trig_state = openload_pkg::TRIG_IDLE;
            end
        endcase

        // registered outputs
        next_s.test_off = (next_s.trig_state == openload_pkg::TRIG_EVAL) ? s.led_mode : 5'h00;
        next_s.led_src = next_s.led_active |
                         ((next_s.trig_state == openload_pkg::TRIG_HOLD) ? s.led_mode : 5'h00);
        next_s.quick = next_s.on_flag | next_s.off_flag;
        next_s.global = |next_s.quick;

        // read data, valid in the cycle after the strobe
        next_s.rdata = 8'h00;
        if (REG_RD) begin
            if (REG_ADDR == openload_pkg::ADDR_FILTER) begin
                next_s.rdata = {3'h0, s.filter_sel};
            end else if (REG_ADDR == openload_pkg::ADDR_LEDCTL) begin
                next_s.rdata = {2'h0, s.trig, s.led_mode};
            end else if (REG_ADDR == openload_pkg::ADDR_OFFTEST) begin
                next_s.rdata = {3'h0, s.off_pending | s.off_active};
            end else if (REG_ADDR == openload_pkg::ADDR_QUICK) begin
                next_s.rdata = {2'h0, s.global, s.quick};
            end else if (REG_ADDR >= openload_pkg::ADDR_CHAN0 && REG_ADDR < openload_pkg::ADDR_CHAN0 + 4'h5) begin
                idx = REG_ADDR - openload_pkg::ADDR_CHAN0;
                next_s.rdata[openload_pkg::STAT_ONSTATE_BIT] = s.on_flag[idx[2:0]];
                next_s.rdata[openload_pkg::STAT_OFFSTATE_BIT] = s.off_flag[idx[2:0]];
                next_s.rdata[openload_pkg::QUICK_GLOBAL_BIT] = s.global;
            end
        end
    end

    // single state register
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.sync1 <= 24'h100000;
            s.sync2 <= 24'h100000;
            s.cs_prev <= 1'b1;
            s.filter_sel <= openload_pkg::FILTER_RESET;
            s.led_mode <= openload_pkg::LEDMODE_RESET;
            s.off_pending <= openload_pkg::OFFTEST_RESET;
            s.trig_state <= openload_pkg::TRIG_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign REG_RDATA = s.rdata;
    assign OFFTEST_DRIVE = s.off_active;
    assign LED_SOURCE_EN = s.led_src;
    assign LED_TEST_OFF = s.test_off;
    assign QUICK_CHANNEL_FAULT = s.quick;
    assign GLOBAL_OPENLOAD_FLAG = s.global;
endmodule

// File: test/host_model.sv
`timescale 1ns/100ps
// host side of the register port; every access is one chip-select frame
module host_model (
    input wire logic CLK_SYS,
    output logic [3:0] REG_ADDR = 4'h0,
    output logic [7:0] REG_WDATA = 8'h00,
    output logic REG_WR = 1'b0,
    output logic REG_RD = 1'b0,
    output logic CHIP_SELECT_N = 1'b1
);
    // host writes mode, trigger and enable bits; the frame end is the rising chip select
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge CLK_SYS);
        CHIP_SELECT_N <= 1'b0;
        REG_ADDR <= a;
        REG_WDATA <= d;
        REG_WR <= 1'b1;
        @(posedge CLK_SYS);
        REG_WR <= 1'b0;
        REG_ADDR <= ~a; // released bus shows no stale value
        REG_WDATA <= ~d;
        CHIP_SELECT_N <= 1'b1;
    endtask
    // status reads are what release latched flags
    task automatic rd(input logic [3:0] a);
        @(posedge CLK_SYS);
        CHIP_SELECT_N <= 1'b0;
        REG_ADDR <= a;
        REG_RD <= 1'b1;
        @(posedge CLK_SYS);
        REG_RD <= 1'b0;
        REG_ADDR <= ~a;
        CHIP_SELECT_N <= 1'b1;
    endtask
endmodule

// File: test/openload_diag_assertions.sv
`timescale 1ns/100ps
module diag_checker #(
    parameter int unsigned LED_WINDOW_CYCLES = openload_pkg::LED_WINDOW_CYCLES,
    parameter int unsigned OFFTEST_CYCLES = openload_pkg::OFFTEST_CYCLES
) (
    input wire logic CLK_SYS,
    input wire logic RSTN,
    input wire logic [3:0] REG_ADDR,
    input wire logic REG_RD,
    input wire logic [7:0] REG_RDATA,
    input wire logic OVERTEMP_SHUTDOWN,
    input wire logic SUPPLY_UNDERVOLTAGE,
    input wire logic CHARGE_PUMP_FAULT,
    input wire logic [4:0] OFFTEST_DRIVE,
    input wire logic [4:0] LED_SOURCE_EN,
    input wire logic [4:0] QUICK_CHANNEL_FAULT,
    input wire logic GLOBAL_OPENLOAD_FLAG
);
    logic [15:0] drive_cnt;
    logic [15:0] src_cnt;
    default clocking cb @(posedge CLK_SYS);
    endclocking
    default disable iff (!RSTN);
    // run lengths of the test drive and the led source, too long for a repetition
    always_ff @(posedge CLK_SYS or negedge RSTN) begin
        if (!RSTN) begin
            drive_cnt <= 16'h0000;
            src_cnt <= 16'h0000;
        end else begin
            drive_cnt <= (|OFFTEST_DRIVE) ? drive_cnt + 16'h0001 : 16'h0000;
            src_cnt <= (|LED_SOURCE_EN) ? src_cnt + 16'h0001 : 16'h0000;
        end
    end
    rdata_idle_a: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
        else $error("read data outside its slot");
    quick_read_a: assert property (REG_RD && REG_ADDR == openload_pkg::ADDR_QUICK |=>
        REG_RDATA == {2'b00, $past(GLOBAL_OPENLOAD_FLAG), $past(QUICK_CHANNEL_FAULT)}) else $error("quick word wrong");
    chan_global_a: assert property (REG_RD && REG_ADDR >= 4'h4 && REG_ADDR <= 4'h8 |=>
        REG_RDATA[5] == $past(GLOBAL_OPENLOAD_FLAG) && REG_RDATA[4:2] == 3'h0) else $error("status word wrong");
    unmapped_a: assert property (REG_RD && REG_ADDR > 4'h8 |=> REG_RDATA == 8'h00)
        else $error("unmapped read not zero");
    // both outputs are registered together, so the global flag must match the or of quick bits every cycle
    global_or_a: assert property (GLOBAL_OPENLOAD_FLAG == (|QUICK_CHANNEL_FAULT))
        else $error("global flag not or of quick bits");
    drive_len_a: assert property (drive_cnt <= OFFTEST_CYCLES + 2)
        else $error("off test drive outlasts timeout");
    drive_group_a: assert property (|$past(OFFTEST_DRIVE) |-> (OFFTEST_DRIVE & ~$past(OFFTEST_DRIVE)) == 5'h00)
        else $error("channel joined a running off test");
    fault_abort_a: assert property ((OVERTEMP_SHUTDOWN || SUPPLY_UNDERVOLTAGE || CHARGE_PUMP_FAULT)[*5]
        |-> OFFTEST_DRIVE == 5'h00) else $error("off test not aborted by fault");
    source_len_a: assert property (src_cnt <= LED_WINDOW_CYCLES + openload_pkg::LED_HOLD_CYCLES + 4)
        else $error("led source on too long");
    cover property ($fell(|OFFTEST_DRIVE));
    cover property ($rose(GLOBAL_OPENLOAD_FLAG));
    cover property ($rose(|LED_SOURCE_EN));
endmodule

bind openload_diag diag_checker #(.LED_WINDOW_CYCLES(LED_WINDOW_CYCLES), .OFFTEST_CYCLES(OFFTEST_CYCLES)) chk (
    .CLK_SYS(CLK_SYS), .RSTN(RSTN), .REG_ADDR(REG_ADDR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .OVERTEMP_SHUTDOWN(OVERTEMP_SHUTDOWN), .SUPPLY_UNDERVOLTAGE(SUPPLY_UNDERVOLTAGE),
    .CHARGE_PUMP_FAULT(CHARGE_PUMP_FAULT), .OFFTEST_DRIVE(OFFTEST_DRIVE), .LED_SOURCE_EN(LED_SOURCE_EN),
    .QUICK_CHANNEL_FAULT(QUICK_CHANNEL_FAULT), .GLOBAL_OPENLOAD_FLAG(GLOBAL_OPENLOAD_FLAG));

// File: test/open_load_diagnostics_test.sv
`timescale 1ns/100ps
module open_load_diagnostics_test;
    logic CLK_SYS = 1'b0;
    logic RSTN = 1'b0;
    logic [4:0] OUT_HIGH = 5'h00, ON_CURRENT_LOW = 5'h00, LED_CMP_HIGH = 5'h00, OFF_CUR_REACHED = 5'h00;
    logic [2:0] fault = 3'h0;
    logic [3:0] REG_ADDR;
    logic [7:0] REG_WDATA, REG_RDATA, e, v;
    logic REG_WR, REG_RD, CHIP_SELECT_N, GLOBAL_OPENLOAD_FLAG, rd_d = 1'b0;
    logic [4:0] OFFTEST_DRIVE, LED_SOURCE_EN, LED_TEST_OFF, QUICK_CHANNEL_FAULT;
    logic [7:0] exp_q[$];
    int bad_count = 0, n_tests = 0;
    host_model host (.CLK_SYS(CLK_SYS), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
        .REG_RD(REG_RD), .CHIP_SELECT_N(CHIP_SELECT_N));
    // short counts keep the run brief; expectations below follow them
    openload_diag #(.FILTER_LONG_CYCLES(50), .LED_WINDOW_CYCLES(60), .OFFTEST_CYCLES(40)) dut (
        .CLK_SYS(CLK_SYS), .RSTN(RSTN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
        .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .CHIP_SELECT_N(CHIP_SELECT_N), .OUT_HIGH(OUT_HIGH),
        .ON_CURRENT_LOW(ON_CURRENT_LOW), .LED_CMP_HIGH(LED_CMP_HIGH), .OFF_CUR_REACHED(OFF_CUR_REACHED),
        .OVERTEMP_SHUTDOWN(fault[0]), .SUPPLY_UNDERVOLTAGE(fault[1]), .CHARGE_PUMP_FAULT(fault[2]),
        .OFFTEST_DRIVE(OFFTEST_DRIVE), .LED_SOURCE_EN(LED_SOURCE_EN), .LED_TEST_OFF(LED_TEST_OFF),
        .QUICK_CHANNEL_FAULT(QUICK_CHANNEL_FAULT), .GLOBAL_OPENLOAD_FLAG(GLOBAL_OPENLOAD_FLAG));
    initial forever #50 CLK_SYS = ~CLK_SYS;
    task automatic check(input string name, input logic [7:0] x, input logic [7:0] got);
        n_tests++;
        if (got !== x) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, x, got);
        end
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] x);
        exp_q.push_back(x);
        host.rd(a);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge CLK_SYS);
    endtask
    // sample port levels mid-cycle, away from the updating edge
    task automatic pin(input string name, input logic [7:0] x, input logic [4:0] sel);
        @(negedge CLK_SYS);
        case (sel)
            5'h0: check(name, x, {3'h0, OFFTEST_DRIVE});
            5'h1: check(name, x, {3'h0, LED_SOURCE_EN});
            5'h2: check(name, x, {3'h0, LED_TEST_OFF});
            default: check(name, x, {2'h0, GLOBAL_OPENLOAD_FLAG, QUICK_CHANNEL_FAULT});
        endcase
        // hand back on a rising edge so stimulus after a check stays edge aligned
        @(posedge CLK_SYS);
    endtask
    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // read results are matched against the oldest note
    always @(posedge CLK_SYS) begin
        rd_d <= REG_RD;
        if (rd_d) begin
            e = exp_q.pop_front();
            check("read data", e, REG_RDATA);
        end
    end
    initial begin
        #2000000;
        bad_count++;
        wrap_up();
    end
    initial begin
        v = $urandom(32'hED6A68E2);
        tick(4);
        RSTN <= 1'b1;
        tick(4);
        v = $urandom;
        rd(openload_pkg::ADDR_LEDCTL, 8'h00);
        rd(openload_pkg::ADDR_OFFTEST, 8'h00);
        rd(4'(9 + $urandom_range(6)), 8'h00);
        host.wr(openload_pkg::ADDR_FILTER, {3'h0, v[4:0]});
        rd(openload_pkg::ADDR_FILTER, {3'h0, v[4:0]});
        host.wr(openload_pkg::ADDR_FILTER, 8'h02);
        $display("registers done");
        OUT_HIGH <= 5'h03;
        ON_CURRENT_LOW <= 5'h03;
        tick(40);
        OUT_HIGH <= 5'h01;
        tick(2);
        OUT_HIGH <= 5'h03;
        tick(40);
        pin("quick", 8'h00, 5'h3);
        tick(700);
        pin("quick", 8'h23, 5'h3);
        pin("test off", 8'h00, 5'h2);
        rd(openload_pkg::ADDR_CHAN0, 8'h21);
        rd(openload_pkg::ADDR_QUICK, 8'h23);
        OUT_HIGH <= 5'h00;
        ON_CURRENT_LOW <= 5'h00;
        tick(5);
        rd(openload_pkg::ADDR_CHAN0, 8'h21);
        rd(4'h5, 8'h21);
        rd(openload_pkg::ADDR_QUICK, 8'h00);
        $display("on-state done");
        host.wr(openload_pkg::ADDR_OFFTEST, 8'h03);
        tick(6);
        pin("drive", 8'h03, 5'h0);
        host.wr(openload_pkg::ADDR_OFFTEST, 8'h00);
        rd(openload_pkg::ADDR_OFFTEST, 8'h03);
        OFF_CUR_REACHED <= 5'h01;
        tick(5);
        pin("drive", 8'h02, 5'h0);
        tick(45);
        pin("drive", 8'h00, 5'h0);
        OFF_CUR_REACHED <= 5'h00;
        rd(openload_pkg::ADDR_OFFTEST, 8'h00);
        rd(openload_pkg::ADDR_QUICK, 8'h22);
        rd(openload_pkg::ADDR_CHAN0, 8'h20);
        rd(4'h5, 8'h22);
        rd(openload_pkg::ADDR_QUICK, 8'h00);
        for (int i = 0; i < 3; i++) begin
            host.wr(openload_pkg::ADDR_OFFTEST, 8'h04);
            tick(6);
            pin("drive", 8'h04, 5'h0);
            fault <= 3'(1 << i);
            tick(6);
            pin("drive", 8'h00, 5'h0);
            fault <= 3'h0;
            rd(openload_pkg::ADDR_QUICK, 8'h00);
        end
        $display("off-state done");
        host.wr(openload_pkg::ADDR_LEDCTL, 8'h04);
        OUT_HIGH <= 5'h04;
        LED_CMP_HIGH <= 5'h04;
        tick(5);
        OUT_HIGH <= 5'h00;
        tick(5);
        pin("source", 8'h04, 5'h1);
        tick(70);
        pin("source", 8'h00, 5'h1);
        rd(openload_pkg::ADDR_QUICK, 8'h24);
        rd(4'h6, 8'h21);
        OUT_HIGH <= 5'h04;
        LED_CMP_HIGH <= 5'h00;
        tick(5);
        OUT_HIGH <= 5'h00;
        tick(8);
        pin("source", 8'h00, 5'h1);
        rd(openload_pkg::ADDR_QUICK, 8'h00);
        OUT_HIGH <= 5'h04;
        host.wr(openload_pkg::ADDR_LEDCTL, 8'h24);
        tick(3);
        pin("test off", 8'h04, 5'h2);
        rd(openload_pkg::ADDR_LEDCTL, 8'h24);
        // evaluation is over, the source is still held for the outputs coming back
        tick(500);
        pin("source", 8'h04, 5'h1);
        pin("test off", 8'h00, 5'h2);
        tick(578);
        pin("source", 8'h00, 5'h1);
        rd(openload_pkg::ADDR_LEDCTL, 8'h04);
        $display("led done");
        tick(4);
        wrap_up();
    end
endmodule
